// ---- hw/dspwu_core.sv ----
// dspwu_core: 16-bit timer with dual-slope and fast pwm waveform generation, apb slave
// assumes apb signals synchronous to pclk; pins resolved outside from pin_out and pin_oe_n
//
// Summary of operation
// - fast pwm: compare at bottom gives one-cycle spike, at top a constant level
// - fast pwm mode 15 with toggle mode: pin a toggles each match
// - modes 1,2,3,10,11 are phase correct: count up to top then down
// - phase correct top is 0xFF/0x1FF/0x3FF, capture value or compare a; top held once
// - dual-slope: mode 2 clears on up-match, sets on down-match; mode 3 inverse
// - phase correct: overflow at bottom; compare a or capture flag at top in modes 11 and 10
// - phase correct: compare values load from buffers at top
// - with fixed top, compare writes mask bits above the resolution
// - every compare match sets the channel's match flag
// - dual-slope non-inverting: compare at bottom is constant low, at top constant high; inverting opposite
// - phase correct mode 11 with toggle mode: pin a toggles each match
// - modes 8,9 are phase and frequency correct; top from capture or compare a
// - phase and frequency correct: load at bottom with overflow; top flag at top
// - phase and frequency correct mode 9 with toggle mode: pin a toggles
// - the pin shows the waveform only when its direction bit is output
// - timer clock is pclk divided by 1, 8, 64, 256 or 1024
// - modes 5,6,7,14,15 are fast pwm: count bottom to top, restart
// - fast pwm: non-inverting clears on match, sets at bottom; inverting opposite
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

module dspwu_core
  import dspwu_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [DSPWU_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic      [DSPWU_NCH-1:0]     pin_out,
  output logic      [DSPWU_NCH-1:0]     pin_oe_n
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  dspwu_ctrl_t                 ctrl;
  logic [15:0]                 cmp_buf    [DSPWU_NCH];
  logic [15:0]                 cmp_act    [DSPWU_NCH];
  logic [15:0]                 capture_top_value;
  logic [15:0]                 timer_count;
  logic                        count_up;
  logic [DSPWU_FLAGS_W-1:0]    flags;
  logic [DSPWU_NCH-1:0]        oc;
  logic [DSPWU_PRE_W-1:0]      pre_cnt;
  logic                        tick;
  logic [15:0]                 top;
  dspwu_cls_t                  cls;
  dspwu_topsrc_t               tsrc;
  logic                        at_top;
  logic                        at_bottom;
  logic                        load_cmp;
  logic                        wr_en;
  logic                        rd_setup;
  logic                        addr_ok;
  logic [DSPWU_NCH-1:0]        match;
  logic [DSPWU_NCH-1:0]        wr_cmp;
  logic [DSPWU_FLAGS_W-1:0]    flag_set;
  logic [DSPWU_FLAGS_W-1:0]    flag_clr;
  logic [15:0]                 next_count;
  logic                        next_up;
  logic [1:0]                  com        [DSPWU_NCH];

  assign cls  = dspwu_class(ctrl.waveform_mode_select);
  assign tsrc = dspwu_topsrc(ctrl.waveform_mode_select);
  assign com[0] = ctrl.compare_output_mode_a;
  assign com[1] = ctrl.compare_output_mode_b;
  assign com[2] = ctrl.compare_output_mode_c;

  // ==========================================================================
  // apb slave
  // ==========================================================================
  function automatic logic dspwu_mapped(input logic [DSPWU_ADDR_W-1:0] a);
    case (a)
      DSPWU_OFS_CTRL, DSPWU_OFS_CMP_A, DSPWU_OFS_CMP_B, DSPWU_OFS_CMP_C,
      DSPWU_OFS_CAPTOP, DSPWU_OFS_COUNT, DSPWU_OFS_FLAGS: dspwu_mapped = 1'b1;
      default:                                            dspwu_mapped = 1'b0;
    endcase
  endfunction

  // zero wait state: read data is captured in the setup cycle
  assign addr_ok  = dspwu_mapped(paddr);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok;
  assign wr_en    = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        DSPWU_OFS_CTRL:   prdata <= {16'h0000, ctrl};
        DSPWU_OFS_CMP_A:  prdata <= {16'h0000, cmp_buf[0]};
        DSPWU_OFS_CMP_B:  prdata <= {16'h0000, cmp_buf[1]};
        DSPWU_OFS_CMP_C:  prdata <= {16'h0000, cmp_buf[2]};
        DSPWU_OFS_CAPTOP: prdata <= {16'h0000, capture_top_value};
        DSPWU_OFS_COUNT:  prdata <= {16'h0000, timer_count};
        DSPWU_OFS_FLAGS:  prdata <= {27'h0000000, flags};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= DSPWU_CTRL_RESET;
    end else if (wr_en && paddr == DSPWU_OFS_CTRL) begin
      ctrl <= pwdata[DSPWU_CTRL_W-1:0];
    end
  end

  // capture top value, not double buffered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_top_value <= DSPWU_CAP_RESET;
    end else if (wr_en && paddr == DSPWU_OFS_CAPTOP) begin
      capture_top_value <= pwdata[15:0];
    end
  end

  // ==========================================================================
  // prescaler
  // ==========================================================================
  function automatic logic dspwu_tick(input logic [2:0] sel, input logic [9:0] p);
    case (sel)
      DSPWU_CS_DIV1:    dspwu_tick = 1'b1;
      DSPWU_CS_DIV8:    dspwu_tick = (p & DSPWU_MSK_8) == '0;
      DSPWU_CS_DIV64:   dspwu_tick = (p & DSPWU_MSK_64) == '0;
      DSPWU_CS_DIV256:  dspwu_tick = (p & DSPWU_MSK_256) == '0;
      DSPWU_CS_DIV1024: dspwu_tick = (p & DSPWU_MSK_1024) == '0;
      default:          dspwu_tick = 1'b0;
    endcase
  endfunction

  // free-running divider, one tick pulse per timer cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  assign tick = dspwu_tick(ctrl.clock_select, pre_cnt);

  // ==========================================================================
  // top selection and counter
  // ==========================================================================
  // top per mode: fixed, capture value, active compare a, else DSPWU_MAX
  always_comb begin
    case (tsrc)
      DSPWU_TOP_FIXED: top = dspwu_fixed_top(ctrl.waveform_mode_select);
      DSPWU_TOP_CAP:   top = capture_top_value;
      DSPWU_TOP_CMPA:  top = cmp_act[0];
      default:         top = DSPWU_MAX;
    endcase
  end

  assign at_top    = timer_count == top;
  assign at_bottom = timer_count == DSPWU_BOTTOM;

  // next count and direction
  always_comb begin
    next_count = timer_count + DSPWU_ONE;
    next_up    = 1'b1;
    case (cls)
      DSPWU_CLS_PC, DSPWU_CLS_PFC: begin
        // dual slope: top and bottom each last one timer cycle
        if (at_top) begin
          next_up    = 1'b0;
          next_count = timer_count - DSPWU_ONE;
        end else if (at_bottom) begin
          next_up    = 1'b1;
          next_count = DSPWU_ONE;
        end else begin
          next_up    = count_up;
          next_count = count_up ? timer_count + DSPWU_ONE : timer_count - DSPWU_ONE;
        end
      end
      DSPWU_CLS_FAST: begin
        next_count = at_top ? DSPWU_BOTTOM : timer_count + DSPWU_ONE;
      end
      default: begin
        next_count = timer_count + DSPWU_ONE;
      end
    endcase
  end

  // timer count and direction advance on the tick only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= DSPWU_BOTTOM;
      count_up    <= 1'b1;
    end else if (tick) begin
      timer_count <= next_count;
      count_up    <= next_up;
    end
  end

  // ==========================================================================
  // compare buffers
  // ==========================================================================
  // update point: top for phase correct and fast, bottom for frequency correct
  always_comb begin
    case (cls)
      DSPWU_CLS_PC:   load_cmp = tick & at_top;
      DSPWU_CLS_PFC:  load_cmp = tick & at_bottom;
      DSPWU_CLS_FAST: load_cmp = tick & at_top;
      default:        load_cmp = 1'b1;             // unbuffered outside pwm
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < DSPWU_NCH; gi++) begin : g_ch
      assign wr_cmp[gi] = wr_en && paddr[DSPWU_ADDR_W-1:DSPWU_CMP_OFS_LSB]
                          == DSPWU_OFS_CMP_A[DSPWU_ADDR_W-1:DSPWU_CMP_OFS_LSB]
                             + (DSPWU_ADDR_W-DSPWU_CMP_OFS_LSB)'(gi);

      // write buffer, unused bits masked with a fixed top
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_buf[gi] <= DSPWU_CMP_RESET;
        end else if (wr_cmp[gi]) begin
          cmp_buf[gi] <= pwdata[15:0] & dspwu_fixed_top(ctrl.waveform_mode_select);
        end
      end

      // active compare value
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_act[gi] <= DSPWU_CMP_RESET;
        end else if (load_cmp) begin
          cmp_act[gi] <= cmp_buf[gi];
        end
      end

      assign match[gi] = timer_count == cmp_act[gi];

      // compare output register
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          oc[gi] <= 1'b0;
        end else if (tick) begin
          if (com[gi] == DSPWU_COM_TGL) begin
            // toggle exists on channel a only, in modes with compare a as top
            if (gi == 0 && tsrc == DSPWU_TOP_CMPA && cls != DSPWU_CLS_NORMAL && match[gi]) begin
              oc[gi] <= ~oc[gi];
            end
          end else if (com[gi] != DSPWU_COM_OFF) begin
            case (cls)
              DSPWU_CLS_PC, DSPWU_CLS_PFC: begin
                // bottom counts as up-slope, top as down-slope
                if (match[gi]) begin
                  if (at_bottom || (count_up && !at_top)) begin
                    oc[gi] <= com[gi] != DSPWU_COM_NINV;
                  end else begin
                    oc[gi] <= com[gi] == DSPWU_COM_NINV;
                  end
                end
              end
              DSPWU_CLS_FAST: begin
                // wrap to bottom wins over a match at top
                if (at_top) begin
                  oc[gi] <= com[gi] == DSPWU_COM_NINV;
                end else if (match[gi]) begin
                  oc[gi] <= com[gi] != DSPWU_COM_NINV;
                end
              end
              default: begin
                oc[gi] <= oc[gi];
              end
            endcase
          end
        end
      end

      // pin drive: connected mode and direction bit both needed
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out[gi]  <= 1'b0;
          pin_oe_n[gi] <= 1'b1;
        end else begin
          pin_out[gi]  <= oc[gi];
          pin_oe_n[gi] <= ~(ctrl.pin_direction_bit[gi] && com[gi] != DSPWU_COM_OFF);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // flags
  // ==========================================================================
  // hardware events for this timer cycle
  always_comb begin
    flag_set = '0;
    if (tick) begin
      flag_set[DSPWU_FLAG_MATCH +: DSPWU_NCH] = match;
      case (cls)
        DSPWU_CLS_PC, DSPWU_CLS_PFC: begin
          flag_set[DSPWU_FLAG_OVF] = at_bottom;
        end
        DSPWU_CLS_FAST: begin
          flag_set[DSPWU_FLAG_OVF] = at_top;
        end
        default: begin
          flag_set[DSPWU_FLAG_OVF] = timer_count == DSPWU_MAX;
        end
      endcase
      if (cls != DSPWU_CLS_NORMAL && at_top) begin
        if (tsrc == DSPWU_TOP_CAP) begin
          flag_set[DSPWU_FLAG_CAP] = 1'b1;
        end
        if (tsrc == DSPWU_TOP_CMPA) begin
          flag_set[DSPWU_FLAG_MATCH] = 1'b1;
        end
      end
    end
  end

  assign flag_clr = (wr_en && paddr == DSPWU_OFS_FLAGS) ? pwdata[DSPWU_FLAGS_W-1:0] : '0;

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

endmodule // dspwu_core

// ---- inc/dspwu_pkg.sv ----
// dspwu_pkg: constants, types and decode helpers for the dual-slope pwm waveform unit
// assumes a 32-bit apb slave with word-aligned registers and a single pclk domain
package dspwu_pkg;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] DSPWU_OFS_CTRL    = 8'h00;
  localparam logic [7:0] DSPWU_OFS_CMP_A   = 8'h04;
  localparam logic [7:0] DSPWU_OFS_CMP_B   = 8'h08;
  localparam logic [7:0] DSPWU_OFS_CMP_C   = 8'h0C;
  localparam logic [7:0] DSPWU_OFS_CAPTOP  = 8'h10;
  localparam logic [7:0] DSPWU_OFS_COUNT   = 8'h14;
  localparam logic [7:0] DSPWU_OFS_FLAGS   = 8'h18;
  localparam int         DSPWU_ADDR_W      = 8;
  localparam int         DSPWU_CMP_OFS_LSB = 2;  // paddr[7:2] holds channel index plus one

  // ==========================================================================
  // field layout
  // ==========================================================================
  localparam int DSPWU_NCH        = 3;
  localparam int DSPWU_CTRL_W     = 16;
  localparam int DSPWU_FLAG_OVF   = 0;
  localparam int DSPWU_FLAG_CAP   = 1;
  localparam int DSPWU_FLAG_MATCH = 2;   // bits 4:2, channel a..c
  localparam int DSPWU_FLAGS_W    = 5;

  localparam logic [DSPWU_CTRL_W-1:0] DSPWU_CTRL_RESET = 16'h0000;
  localparam logic [15:0]             DSPWU_CMP_RESET  = 16'h0000;
  localparam logic [15:0]             DSPWU_CAP_RESET  = 16'h0000;

  // control register, packed from bit 15 down to bit 0
  typedef struct packed {
    logic [2:0] pin_direction_bit;     // 15:13 one per channel, 1 = output
    logic [2:0] clock_select;          // 12:10 prescaler choice
    logic [1:0] compare_output_mode_c; // 9:8
    logic [1:0] compare_output_mode_b; // 7:6
    logic [1:0] compare_output_mode_a; // 5:4
    logic [3:0] waveform_mode_select;  // 3:0
  } dspwu_ctrl_t;

  // ==========================================================================
  // counting limits and compare output modes
  // ==========================================================================
  localparam logic [15:0] DSPWU_BOTTOM   = 16'h0000;
  localparam logic [15:0] DSPWU_ONE      = 16'h0001;
  localparam logic [15:0] DSPWU_MAX      = 16'hFFFF;
  localparam logic [15:0] DSPWU_TOP_8B   = 16'h00FF;
  localparam logic [15:0] DSPWU_TOP_9B   = 16'h01FF;
  localparam logic [15:0] DSPWU_TOP_10B  = 16'h03FF;
  localparam logic [1:0]  DSPWU_COM_OFF  = 2'h0;
  localparam logic [1:0]  DSPWU_COM_TGL  = 2'h1;
  localparam logic [1:0]  DSPWU_COM_NINV = 2'h2;

  // ==========================================================================
  // prescaler selections and divider masks
  // ==========================================================================
  localparam logic [2:0] DSPWU_CS_DIV1    = 3'h1;
  localparam logic [2:0] DSPWU_CS_DIV8    = 3'h2;
  localparam logic [2:0] DSPWU_CS_DIV64   = 3'h3;
  localparam logic [2:0] DSPWU_CS_DIV256  = 3'h4;
  localparam logic [2:0] DSPWU_CS_DIV1024 = 3'h5;
  localparam int         DSPWU_PRE_W      = 10;
  localparam logic [9:0] DSPWU_MSK_8      = 10'h007;
  localparam logic [9:0] DSPWU_MSK_64     = 10'h03F;
  localparam logic [9:0] DSPWU_MSK_256    = 10'h0FF;
  localparam logic [9:0] DSPWU_MSK_1024   = 10'h3FF;

  // ==========================================================================
  // waveform mode classes
  // ==========================================================================
  typedef enum logic [1:0] {
    DSPWU_CLS_NORMAL = 2'b00,
    DSPWU_CLS_PC     = 2'b01,
    DSPWU_CLS_PFC    = 2'b10,
    DSPWU_CLS_FAST   = 2'b11
  } dspwu_cls_t;

  // which top source a mode uses
  typedef enum logic [1:0] {
    DSPWU_TOP_FIXED = 2'b00,
    DSPWU_TOP_CAP   = 2'b01,
    DSPWU_TOP_CMPA  = 2'b10,
    DSPWU_TOP_FULL  = 2'b11
  } dspwu_topsrc_t;

  function automatic dspwu_cls_t dspwu_class(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: dspwu_class = DSPWU_CLS_PC;
      4'h8, 4'h9:                   dspwu_class = DSPWU_CLS_PFC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: dspwu_class = DSPWU_CLS_FAST;
      default:                      dspwu_class = DSPWU_CLS_NORMAL;
    endcase
  endfunction

  function automatic dspwu_topsrc_t dspwu_topsrc(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: dspwu_topsrc = DSPWU_TOP_FIXED;
      4'h8, 4'hA, 4'hE:                   dspwu_topsrc = DSPWU_TOP_CAP;
      4'h9, 4'hB, 4'hF:                   dspwu_topsrc = DSPWU_TOP_CMPA;
      default:                            dspwu_topsrc = DSPWU_TOP_FULL;
    endcase
  endfunction

  // fixed resolution mask, also the fixed top value
  function automatic logic [15:0] dspwu_fixed_top(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: dspwu_fixed_top = DSPWU_TOP_8B;
      4'h2, 4'h6: dspwu_fixed_top = DSPWU_TOP_9B;
      4'h3, 4'h7: dspwu_fixed_top = DSPWU_TOP_10B;
      default:    dspwu_fixed_top = DSPWU_MAX;
    endcase
  endfunction

endpackage

// ---- dv/dspwu_chk.sv ----
// dspwu_chk: port-level assertions for the dual-slope pwm waveform unit
// assumes one pclk domain and the zero-wait apb slave of dspwu_core
`timescale 1ns/1ps

module dspwu_chk
  import dspwu_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [DSPWU_ADDR_W-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [DSPWU_NCH-1:0]    pin_out,
  input wire logic [DSPWU_NCH-1:0]    pin_oe_n
);
  // ==========================================================================
  // shadow of the control register
  // ==========================================================================
  dspwu_ctrl_t ctl;
  logic [1:0]  age;
  logic        acc;
  logic        run;
  logic [2:0]  oe_exp;

  // access phase, enables derived from the shadow
  assign acc    = psel && penable && pready;
  assign run    = ctl.clock_select inside {[3'h1:3'h5]};
  assign oe_exp = ~(ctl.pin_direction_bit & {ctl.compare_output_mode_c != 2'h0,
                    ctl.compare_output_mode_b != 2'h0, ctl.compare_output_mode_a != 2'h0});

  // follow control writes and count cycles since the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= DSPWU_CTRL_RESET;
      age <= 2'h0;
    end else if (acc && pwrite && paddr == DSPWU_OFS_CTRL) begin
      ctl <= pwdata[15:0];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_err_map: assert property (acc |-> pslverr == (paddr > DSPWU_OFS_FLAGS || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address");
  chk_err_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata changed without read");
  chk_oe_dir: assert property (age[1] |-> pin_oe_n == oe_exp)
    else $error("pin enable does not follow control");
  chk_stop_hold: assert property (!run && age[1] |=> $stable(pin_out))
    else $error("pin moved while timer stopped");

endmodule // dspwu_chk

bind dspwu_core dspwu_chk u_dspwu_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ---- dv/testbench.sv ----
// testbench: self-checking bench for dspwu_core over apb and its pwm pins
// assumes zero-wait apb answers and a fresh reset before each waveform row
`timescale 1ns/1ps

module testbench
  import dspwu_pkg::*;
;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe_n;
  int          failures = 0;
  int          checks   = 0;
  int          seed     = 32'h2392;
  logic [31:0] exp_q [$];

  // ==========================================================================
  // design and clock
  // ==========================================================================
  dspwu_core u_dspwu_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

  // 125 MHz clock
  always #4 pclk = ~pclk;

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic stall;
    failures++;
    $display("unexpected at %0t: wait timed out", $time);
    end_sim();
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // one apb transfer, held until pready is seen
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) stall();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask

  task automatic wr_ctrl(input logic [3:0] m, input logic [1:0] ma, mb, mc,
                         input logic [2:0] cs, dir);
    dspwu_ctrl_t c;
    c = '{dir, cs, mc, mb, ma, m};
    apb(DSPWU_OFS_CTRL, 1'b1, {16'h0000, c});
  endtask

  // period of one pin between rises, with high cycles of all pins
  task automatic measure(input int ch, output int per, output int hi [3]);
    int n;
    logic p;
    p = 1'b1;
    n = 0;
    hi = '{0, 0, 0};
    while (!(pin_out[ch] === 1'b1 && p === 1'b0) && n < 40000) begin
      p = pin_out[ch];
      @(posedge pclk);
      n++;
    end
    per = 0;
    do begin
      for (int i = 0; i < 3; i++) hi[i] += pin_out[i];
      p = pin_out[ch];
      @(posedge pclk);
      per++;
    end while (!(pin_out[ch] === 1'b1 && p === 1'b0) && per < 40000);
    if (n >= 40000 || per >= 40000) stall();
  endtask

  // top 4, compare a 4, b 2, c 0, all pins driven
  task automatic run_row(input logic [3:0] m, input logic [1:0] ma, mb, mc,
                         input logic [2:0] cs, input int ch, per, ha, hb, hc);
    int gp;
    int gh [3];
    do_reset();
    apb(DSPWU_OFS_CAPTOP, 1'b1, 32'h4);
    apb(DSPWU_OFS_CMP_A, 1'b1, 32'h4);
    apb(DSPWU_OFS_CMP_B, 1'b1, 32'h2);
    wr_ctrl(m, ma, mb, mc, cs, 3'h7);
    repeat (2) @(posedge pclk);
    chk(pin_oe_n, 3'h0);
    measure(ch, gp, gh);
    chk(gp, per);
    chk(gh[0], ha);
    chk(gh[1], hb);
    chk(gh[2], hc);
  endtask

  // compare each read answer with the oldest noted value
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk(prdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hXXXXXXXX);
    end
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    int v;
    int nf [5];
    logic [15:0] tf [3];
    nf = '{1, 8, 64, 256, 1024};
    tf = '{16'h00FF, 16'h01FF, 16'h03FF};
    do_reset();
    for (int a = 0; a <= 24; a += 4) rd(8'(a), 32'h0);
    apb(8'h1C, 1'b1, 32'hFFFF);
    rd(8'h1C, 32'h0);
    apb(DSPWU_OFS_COUNT, 1'b1, 32'h1234);
    rd(DSPWU_OFS_COUNT, 32'h0);
    for (int m = 1; m <= 3; m++) begin
      wr_ctrl(4'(m), 2'h0, 2'h0, 2'h0, 3'h0, 3'h0);
      for (int c = 0; c < 3; c++) begin
        v = $random(seed);
        apb(8'(4 + 4 * c), 1'b1, v);
        rd(8'(4 + 4 * c), {16'h0000, v[15:0] & tf[m-1]});
      end
    end
    for (int k = 0; k < 5; k++) begin
      run_row(4'hA, 2'h2, 2'h2, 2'h3, 3'(k + 1), 1,
              8 * nf[k], 8 * nf[k], 4 * nf[k], 8 * nf[k]);
    end
    wr_ctrl(4'hA, 2'h2, 2'h0, 2'h3, 3'h0, 3'h3);
    rd(DSPWU_OFS_FLAGS, 32'h1F);
    apb(DSPWU_OFS_FLAGS, 1'b1, 32'h1F);
    rd(DSPWU_OFS_FLAGS, 32'h0);
    chk(pin_oe_n, 3'h6);
    run_row(4'h8, 2'h2, 2'h2, 2'h3, 3'h1, 1, 8, 8, 4, 8);
    run_row(4'h9, 2'h1, 2'h2, 2'h3, 3'h1, 0, 16, 8, 8, 16);
    run_row(4'hB, 2'h1, 2'h2, 2'h3, 3'h1, 0, 16, 8, 8, 16);
    run_row(4'hF, 2'h1, 2'h2, 2'h2, 3'h1, 0, 10, 5, 6, 2);
    // capture top in fast mode: a at top stays high, c inverting gives a one-cycle dip
    run_row(4'hE, 2'h2, 2'h2, 2'h3, 3'h1, 1, 5, 5, 3, 4);
    for (int m = 5; m <= 7; m++) begin
      run_row(4'(m), 2'h2, 2'h2, 2'h2, 3'h1, 1, tf[m-5] + 1, 5, 3, 1);
    end
    for (int m = 1; m <= 3; m++) begin
      run_row(4'(m), 2'h2, 2'h2, 2'h3, 3'h1, 1, 2 * tf[m-1], 8, 4, 2 * tf[m-1]);
    end
    end_sim();
  end

endmodule // testbench
